// ==== design/gdm_pkg.sv ====
// Purpose: constants and carriers for the detector register map
// Assumes: frame decoding and checksum handled upstream
// Notes: none
package gdm_pkg;
  localparam int NUM_SENS = 4;
  localparam logic [15:0] ADDR_VALUE = 16'h0000;
  localparam logic [15:0] ADDR_STATUS = 16'h0020;
  localparam logic [15:0] ADDR_OVERALL = 16'h0040;
  localparam logic [15:0] ADDR_PUMP_INT = 16'h0041;
  localparam logic [15:0] ADDR_PUMP_USER = 16'h0042;
  localparam logic [15:0] ADDR_LOW_LIM = 16'h0200;
  localparam logic [15:0] ADDR_UP_LIM = 16'h0220;
  localparam logic [15:0] ADDR_GAS = 16'h0240;
  localparam logic [16:0] ADDR_MAP_END = 17'h0_025F;
  localparam logic [4:0] MAX_READ = 5'h10;
  localparam logic [15:0] READ_INVALID = 16'hFFFF;
  localparam logic [15:0] READ_MAX = 16'hFFFE;
  localparam logic [9:0] SCALE_X1 = 10'h001;
  localparam logic [9:0] SCALE_X10 = 10'h00A;
  localparam logic [9:0] SCALE_X100 = 10'h064;
  localparam logic [9:0] SCALE_X1000 = 10'h3E8;
  localparam logic [15:0] COIL_PUMP_RESET = 16'h1001;
  localparam logic [15:0] COIL_CLR_USER = 16'h1002;
  localparam logic [15:0] COIL_RSVD_LO = 16'h1003;
  localparam logic [15:0] COIL_RSVD_HI = 16'h1FFF;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  localparam logic [15:0] COIL_ON_A = 16'h00FF;
  localparam logic [15:0] COIL_ON_B = 16'hFF00;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [3:0] ST_NEG = 4'h0;
  localparam logic [3:0] ST_LOW = 4'h1;
  localparam logic [3:0] ST_HIGH = 4'h2;
  localparam logic [3:0] ST_OVR = 4'h3;
  localparam logic [3:0] ST_SAFE = 4'h4;
  localparam logic [3:0] ST_CLEAR = 4'h5;
  localparam logic [3:0] ST_FAIL = 4'h6;
  localparam logic [3:0] ST_CAL = 4'h7;
  localparam logic [3:0] ST_NONE = 4'h8;
  localparam logic [3:0] ST_OVR_DUAL = 4'h9;
  localparam logic [3:0] ST_ERR2 = 4'hA;
  localparam logic [3:0] ST_ERR3 = 4'hB;
  localparam logic [3:0] ST_ERR4 = 4'hC;
  localparam logic signed [15:0] GAS_INVALID = 16'shFFFF;
  localparam logic signed [15:0] GAS_NONE = 16'sh0000;
  localparam int OV_UNSAFE = 0;
  localparam int OV_GAS = 1;
  localparam int OV_PUMP = 2;
  localparam int OV_RELAY = 3;
  localparam int OV_BATT = 4;
  localparam int OV_BOOT = 5;
  localparam int OV_MENU = 6;
  localparam logic [15:0] USER_HOURS_RST = 16'h0000;

  typedef struct packed {
    logic [15:0] meas;
    logic [1:0] scale;
    logic installed;
    logic failing;
    logic needs_cal;
    logic reading_negative;
    logic dual_range;
    logic [1:0] err_code;
    logic [15:0] lower_lim;
    logic [15:0] upper_lim;
    logic [15:0] range_max;
    logic [15:0] dead_band;
    logic signed [15:0] gas_code;
  } gdm_sensor_s;

  typedef struct packed {
    logic pump_alarm;
    logic relay_on;
    logic on_battery;
    logic booting;
    logic in_menu;
  } gdm_sys_s;

  typedef enum logic {GDM_IDLE, GDM_SEND} gdm_rd_e;
endpackage : gdm_pkg

// ==== design/gdm_regmap.sv ====
// Purpose: holding registers and command coils of the gas detector slave
// Assumes: decoded function 3 and 5 requests arrive as one-cycle strobes
// Notes: readings and codes refresh every clock from the sensor inputs
`timescale 1ns/1ps
module gdm_regmap (
  input wire logic sys_clk,
  input wire logic rst,
  input gdm_pkg::gdm_sensor_s sensor_in [gdm_pkg::NUM_SENS],
  input gdm_pkg::gdm_sys_s sys_in,
  input wire logic hour_tick,
  input wire logic [15:0] internal_pump_hours,
  input wire logic rd_start,
  input wire logic [15:0] rd_addr,
  input wire logic [4:0] rd_count,
  output logic rd_busy,
  output logic rd_word_valid,
  output logic [15:0] rd_word,
  output logic rd_last,
  output logic rd_fault,
  output logic [7:0] rd_fault_code,
  input wire logic coil_req,
  input wire logic [15:0] coil_addr,
  input wire logic [15:0] coil_value,
  output logic coil_ack,
  output logic coil_fault,
  output logic [7:0] coil_fault_code,
  output logic pump_reset,
  output logic [15:0] overall_word,
  output logic [15:0] user_pump_hours
);
  // ----------------------------------------
  // per-sensor reading and condition
  // ----------------------------------------
  logic [15:0] val_reg [gdm_pkg::NUM_SENS];
  logic [3:0] stat_reg [gdm_pkg::NUM_SENS];
  logic signed [15:0] gas_reg [gdm_pkg::NUM_SENS];
  logic [gdm_pkg::NUM_SENS-1:0] alarm_now;
  logic [gdm_pkg::NUM_SENS-1:0] alarm_reg;

  genvar gi;
  generate
    for (gi = 0; gi < gdm_pkg::NUM_SENS; gi++) begin : g_sens
      logic [9:0] mult;
      logic [25:0] prod;
      logic [15:0] scaled;
      logic [3:0] code;
      logic err;
      always_comb begin
        unique case (sensor_in[gi].scale)
          2'h0: mult = gdm_pkg::SCALE_X1;
          2'h1: mult = gdm_pkg::SCALE_X10;
          2'h2: mult = gdm_pkg::SCALE_X100;
          default: mult = gdm_pkg::SCALE_X1000;
        endcase
        prod = sensor_in[gi].meas * mult;
        // clamp keeps the error code free
        if (prod > 26'(gdm_pkg::READ_MAX)) begin
          scaled = gdm_pkg::READ_MAX;
        end else begin
          scaled = prod[15:0];
        end
      end
      always_comb begin
        err = 1'b0;
        if (!sensor_in[gi].installed) begin
          code = gdm_pkg::ST_NONE;
        end else if (sensor_in[gi].failing) begin
          code = gdm_pkg::ST_FAIL;
          err = 1'b1;
        end else if (sensor_in[gi].err_code != 2'h0) begin
          code = gdm_pkg::ST_FAIL + 4'(sensor_in[gi].err_code) + 4'h3;
          err = 1'b1;
        end else if (sensor_in[gi].needs_cal) begin
          code = gdm_pkg::ST_CAL;
        end else if (sensor_in[gi].reading_negative) begin
          code = gdm_pkg::ST_NEG;
        end else if (scaled > sensor_in[gi].range_max) begin
          code = sensor_in[gi].dual_range ? gdm_pkg::ST_OVR_DUAL : gdm_pkg::ST_OVR;
        end else if (scaled > sensor_in[gi].upper_lim) begin
          code = gdm_pkg::ST_HIGH;
        end else if (scaled > sensor_in[gi].lower_lim) begin
          code = gdm_pkg::ST_LOW;
        end else if (scaled <= sensor_in[gi].dead_band) begin
          code = gdm_pkg::ST_CLEAR;
        end else begin
          code = gdm_pkg::ST_SAFE;
        end
      end
      assign alarm_now[gi] = !(code == gdm_pkg::ST_SAFE || code == gdm_pkg::ST_CLEAR
                               || code == gdm_pkg::ST_NONE);
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          val_reg[gi] <= gdm_pkg::READ_INVALID;
          stat_reg[gi] <= gdm_pkg::ST_NONE;
          gas_reg[gi] <= gdm_pkg::GAS_NONE;
          alarm_reg[gi] <= 1'b0;
        end else begin
          stat_reg[gi] <= code;
          alarm_reg[gi] <= alarm_now[gi];
          if (sys_in.booting || err) begin
            val_reg[gi] <= gdm_pkg::READ_INVALID;
          end else if (!sensor_in[gi].installed) begin
            val_reg[gi] <= 16'h0000;
          end else begin
            val_reg[gi] <= scaled;
          end
          if (!sensor_in[gi].installed) begin
            gas_reg[gi] <= gdm_pkg::GAS_NONE;
          end else if (sensor_in[gi].gas_code < gdm_pkg::GAS_INVALID) begin
            gas_reg[gi] <= gdm_pkg::GAS_INVALID;
          end else begin
            gas_reg[gi] <= sensor_in[gi].gas_code;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // overall condition word
  // ----------------------------------------
  logic [15:0] overall_next;
  always_comb begin
    overall_next = 16'h0000;
    overall_next[gdm_pkg::OV_GAS] = |alarm_now;
    overall_next[gdm_pkg::OV_PUMP] = sys_in.pump_alarm;
    overall_next[gdm_pkg::OV_UNSAFE] = (|alarm_now) | sys_in.pump_alarm;
    overall_next[gdm_pkg::OV_RELAY] = sys_in.relay_on;
    overall_next[gdm_pkg::OV_BATT] = sys_in.on_battery;
    overall_next[gdm_pkg::OV_BOOT] = sys_in.booting;
    overall_next[gdm_pkg::OV_MENU] = sys_in.in_menu;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      overall_word <= 16'h0000;
    end else begin
      overall_word <= overall_next;
    end
  end

  // ----------------------------------------
  // command coils
  // ----------------------------------------
  logic coil_on;
  logic coil_val_ok;
  logic coil_addr_ok;
  assign coil_on = coil_value == gdm_pkg::COIL_ON_A || coil_value == gdm_pkg::COIL_ON_B;
  assign coil_val_ok = coil_on || coil_value == gdm_pkg::COIL_OFF;
  assign coil_addr_ok = coil_addr >= gdm_pkg::COIL_PUMP_RESET
                        && coil_addr <= gdm_pkg::COIL_RSVD_HI;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      coil_ack <= 1'b0;
      coil_fault <= 1'b0;
      coil_fault_code <= 8'h00;
      pump_reset <= 1'b0;
    end else begin
      coil_ack <= coil_req;
      coil_fault <= coil_req && !(coil_addr_ok && coil_val_ok);
      coil_fault_code <= !coil_req ? 8'h00 : !coil_addr_ok ? gdm_pkg::EXC_ADDR
                         : !coil_val_ok ? gdm_pkg::EXC_VALUE : 8'h00;
      pump_reset <= coil_req && coil_on && coil_addr == gdm_pkg::COIL_PUMP_RESET;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      user_pump_hours <= gdm_pkg::USER_HOURS_RST;
    end else if (coil_req && coil_on && coil_addr == gdm_pkg::COIL_CLR_USER) begin
      user_pump_hours <= 16'h0000;
    end else if (hour_tick && user_pump_hours != 16'hFFFF) begin
      user_pump_hours <= user_pump_hours + 16'h0001;
    end
  end

  // ----------------------------------------
  // holding register reads
  // ----------------------------------------
  gdm_pkg::gdm_rd_e rd_state;
  logic [15:0] ptr_reg;
  logic [4:0] left_reg;
  logic [15:0] look;
  logic [16:0] end_addr;
  logic [1:0] si;
  logic in_sens;
  assign rd_busy = rd_state == gdm_pkg::GDM_SEND;
  assign end_addr = {1'b0, rd_addr} + {12'h000, rd_count} - 17'h0_0001;
  assign si = ptr_reg[1:0];
  assign in_sens = ptr_reg[4:0] < 5'(gdm_pkg::NUM_SENS);

  always_comb begin
    look = 16'h0000;
    unique case ({ptr_reg[15:5], 5'h00})
      gdm_pkg::ADDR_VALUE: look = in_sens ? val_reg[si] : 16'h0000;
      gdm_pkg::ADDR_STATUS: look = in_sens ? {12'h000, stat_reg[si]} : 16'h0000;
      gdm_pkg::ADDR_LOW_LIM: look = in_sens ? sensor_in[si].lower_lim : 16'h0000;
      gdm_pkg::ADDR_UP_LIM: look = in_sens ? sensor_in[si].upper_lim : 16'h0000;
      gdm_pkg::ADDR_GAS: look = in_sens ? gas_reg[si] : 16'h0000;
      default: begin
        if (ptr_reg == gdm_pkg::ADDR_OVERALL) begin
          look = overall_word;
        end else if (ptr_reg == gdm_pkg::ADDR_PUMP_INT) begin
          look = internal_pump_hours;
        end else if (ptr_reg == gdm_pkg::ADDR_PUMP_USER) begin
          look = user_pump_hours;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_state <= gdm_pkg::GDM_IDLE;
      ptr_reg <= 16'h0000;
      left_reg <= 5'h00;
      rd_word_valid <= 1'b0;
      rd_word <= 16'h0000;
      rd_last <= 1'b0;
      rd_fault <= 1'b0;
      rd_fault_code <= 8'h00;
    end else begin
      rd_word_valid <= 1'b0;
      rd_last <= 1'b0;
      rd_fault <= 1'b0;
      rd_fault_code <= 8'h00;
      unique case (rd_state)
        gdm_pkg::GDM_IDLE: begin
          if (rd_start) begin
            if (rd_count == 5'h00 || rd_count > gdm_pkg::MAX_READ) begin
              rd_fault <= 1'b1;
              rd_fault_code <= gdm_pkg::EXC_VALUE;
            end else if (end_addr > gdm_pkg::ADDR_MAP_END) begin
              rd_fault <= 1'b1;
              rd_fault_code <= gdm_pkg::EXC_ADDR;
            end else begin
              rd_state <= gdm_pkg::GDM_SEND;
              ptr_reg <= rd_addr;
              left_reg <= rd_count;
            end
          end
        end
        gdm_pkg::GDM_SEND: begin
          rd_word_valid <= 1'b1;
          rd_word <= look;
          ptr_reg <= ptr_reg + 16'h0001;
          left_reg <= left_reg - 5'h01;
          if (left_reg == 5'h01) begin
            rd_last <= 1'b1;
            rd_state <= gdm_pkg::GDM_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_boot_invalid: assert property (@(posedge sys_clk) disable iff (rst)
    $past(sys_in.booting) && !$past(rst) |-> val_reg[0] == 16'hFFFF && val_reg[3] == 16'hFFFF)
    else $error("reading not invalid while booting");
  a_fail_invalid: assert property (@(posedge sys_clk) disable iff (rst)
    stat_reg[0] == 4'h6 || stat_reg[0] >= 4'hA |-> val_reg[0] == 16'hFFFF)
    else $error("failing sensor reading not invalid");
  a_good_max: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(sys_in.booting) && stat_reg[0] == 4'h4 && !$past(rst) |-> val_reg[0] <= 16'hFFFE)
    else $error("good reading above limit");
  a_no_sensor: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(sensor_in[3].installed) && !$past(rst) |-> stat_reg[3] == 4'h8 && gas_reg[3] == 0)
    else $error("absent sensor not coded 8");
  a_rsvd_zero: assert property (@(posedge sys_clk) disable iff (rst)
    overall_word[15:7] == 9'h000)
    else $error("reserved status bits set");
  a_gas_bit: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(rst) |-> overall_word[1] == |alarm_reg && overall_word[0] >= overall_word[1])
    else $error("gas alarm bit wrong");
  a_pump_cmd: assert property (@(posedge sys_clk) disable iff (rst)
    coil_req && coil_addr == 16'h1001 && coil_value == 16'hFF00 |=> pump_reset && coil_ack)
    else $error("pump reset not pulsed");
  a_coil_off: assert property (@(posedge sys_clk) disable iff (rst)
    coil_req && coil_value == 16'h0000 && coil_addr >= 16'h1001 && coil_addr <= 16'h1FFF
    |=> !pump_reset && !coil_fault && coil_ack ##1 (!pump_reset || $past(coil_req)))
    else $error("off value acted");
  a_user_clear: assert property (@(posedge sys_clk) disable iff (rst)
    coil_req && coil_addr == 16'h1002 && coil_value == 16'h00FF |=> user_pump_hours == 0)
    else $error("user count not cleared");
  a_read_pair: assert property (@(posedge sys_clk) disable iff (rst)
    !rd_busy && rd_start && rd_addr == 16'h0040 && rd_count == 5'h02
    |=> ##1 rd_word_valid && !rd_last ##1 rd_word_valid && rd_last ##1 !rd_busy)
    else $error("two-word read misframed");
  a_read_limit: assert property (@(posedge sys_clk) disable iff (rst)
    !rd_busy && rd_start && rd_count > 5'h10 |=> rd_fault && !rd_busy)
    else $error("oversize read accepted");
  a_coil_range: assert property (@(posedge sys_clk) disable iff (rst)
    coil_req && coil_addr >= 16'h1003 && coil_addr <= 16'h1FFF && coil_value == 16'hFF00
    |=> coil_ack && !coil_fault && !pump_reset)
    else $error("reserved coil acted or refused");
  a_user_hold: assert property (@(posedge sys_clk) disable iff (rst)
    coil_req && coil_addr == 16'h1002 && coil_value == 16'h0000 && !hour_tick
    |=> user_pump_hours == $past(user_pump_hours))
    else $error("user count changed by off value");
  a_boot_bit: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(rst) |-> overall_word[5] == $past(sys_in.booting)
    && overall_word[6] == $past(sys_in.in_menu))
    else $error("boot or menu bit wrong");
  a_pump_bit: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(rst) |-> overall_word[2] == $past(sys_in.pump_alarm) && overall_word[0] >= overall_word[2])
    else $error("pump alarm bit wrong");
  a_relay_batt: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(rst) |-> overall_word[4:3] == {$past(sys_in.on_battery), $past(sys_in.relay_on)})
    else $error("relay or battery bit wrong");
endmodule : gdm_regmap

// ==== bench/gdm_master_model.sv ====
// Purpose: remote master issuing decoded read and coil requests
// Assumes: requests are launched on falling edges of sys_clk
// Notes: released address and data lines carry inverted values
`timescale 1ns/1ps
module gdm_master_model (
  input wire logic sys_clk,
  output logic rd_start,
  output logic [15:0] rd_addr,
  output logic [4:0] rd_count,
  input wire logic rd_busy,
  input wire logic rd_word_valid,
  input wire logic [15:0] rd_word,
  input wire logic rd_last,
  input wire logic rd_fault,
  input wire logic [7:0] rd_fault_code,
  output logic coil_req,
  output logic [15:0] coil_addr,
  output logic [15:0] coil_value,
  input wire logic coil_ack,
  input wire logic coil_fault,
  input wire logic [7:0] coil_fault_code
);
  logic [15:0] words [$];
  logic [7:0] fault_code;
  logic got_ack;
  logic got_fault;
  logic busy_seen;
  initial begin
    rd_start = 1'b0;
    rd_addr = 16'h0000;
    rd_count = 5'h00;
    coil_req = 1'b0;
    coil_addr = 16'h0000;
    coil_value = 16'h0000;
  end
  // function 3 burst, collected until last word or fault
  task automatic do_read(input logic [15:0] addr, input logic [4:0] cnt);
    logic done;
    words.delete();
    fault_code = 8'h00;
    done = 1'b0;
    @(negedge sys_clk);
    rd_start = 1'b1;
    rd_addr = addr;
    rd_count = cnt;
    @(negedge sys_clk);
    rd_start = 1'b0;
    rd_addr = ~addr;
    rd_count = ~cnt;
    busy_seen = rd_busy;
    for (int i = 0; i < 24 && !done; i++) begin
      if (rd_fault === 1'b1) begin
        fault_code = rd_fault_code;
        done = 1'b1;
      end else if (rd_word_valid === 1'b1) begin
        words.push_back(rd_word);
        done = (rd_last === 1'b1);
      end
      if (!done) begin
        @(negedge sys_clk);
      end
    end
  endtask : do_read
  // function 5 single coil write
  task automatic do_coil(input logic [15:0] addr, input logic [15:0] val);
    @(negedge sys_clk);
    coil_req = 1'b1;
    coil_addr = addr;
    coil_value = val;
    @(negedge sys_clk);
    coil_req = 1'b0;
    coil_addr = ~addr;
    coil_value = ~val;
    got_ack = coil_ack;
    got_fault = coil_fault;
    fault_code = coil_fault_code;
  endtask : do_coil
endmodule : gdm_master_model

// ==== bench/tb.sv ====
// Purpose: self-checking bench for the detector register map
// Assumes: inputs change on falling edges; no random stimulus
// Notes: sensor registers lag inputs, so each test except t_coil settles first
`timescale 1ns/1ps
module tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  gdm_pkg::gdm_sensor_s sensor_in [gdm_pkg::NUM_SENS];
  gdm_pkg::gdm_sys_s sys_in = '0;
  logic hour_tick = 1'b0;
  logic [15:0] internal_pump_hours = 16'h1234;
  logic rd_start, rd_busy, rd_word_valid, rd_last, rd_fault;
  logic [15:0] rd_addr, rd_word, coil_addr, coil_value, overall_word, user_pump_hours;
  logic [4:0] rd_count;
  logic [7:0] rd_fault_code, coil_fault_code;
  logic coil_req, coil_ack, coil_fault, pump_reset;
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #10 sys_clk = ~sys_clk;
  gdm_regmap gdm_regmap_inst (.sys_clk(sys_clk), .rst(rst), .sensor_in(sensor_in),
    .sys_in(sys_in), .hour_tick(hour_tick), .internal_pump_hours(internal_pump_hours),
    .rd_start(rd_start), .rd_addr(rd_addr), .rd_count(rd_count), .rd_busy(rd_busy),
    .rd_word_valid(rd_word_valid), .rd_word(rd_word), .rd_last(rd_last), .rd_fault(rd_fault),
    .rd_fault_code(rd_fault_code), .coil_req(coil_req), .coil_addr(coil_addr),
    .coil_value(coil_value), .coil_ack(coil_ack), .coil_fault(coil_fault),
    .coil_fault_code(coil_fault_code), .pump_reset(pump_reset),
    .overall_word(overall_word), .user_pump_hours(user_pump_hours));
  gdm_master_model gdm_master_model_inst (.sys_clk(sys_clk), .rd_start(rd_start),
    .rd_addr(rd_addr), .rd_count(rd_count), .rd_busy(rd_busy), .rd_word_valid(rd_word_valid),
    .rd_word(rd_word), .rd_last(rd_last), .rd_fault(rd_fault), .rd_fault_code(rd_fault_code),
    .coil_req(coil_req), .coil_addr(coil_addr), .coil_value(coil_value), .coil_ack(coil_ack),
    .coil_fault(coil_fault), .coil_fault_code(coil_fault_code));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk16(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk16
  task automatic chk1(input string nm, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk1
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  function automatic gdm_pkg::gdm_sensor_s mk(input logic [15:0] meas, input logic [1:0] sc);
    gdm_pkg::gdm_sensor_s s;
    s = '0;
    s.meas = meas;
    s.scale = sc;
    s.installed = 1'b1;
    s.lower_lim = 16'h0064;
    s.upper_lim = 16'h00C8;
    s.range_max = 16'h03E8;
    s.dead_band = 16'h0005;
    s.gas_code = 16'sh0001;
    return s;
  endfunction : mk
  task automatic rd(input logic [15:0] a, input logic [4:0] c);
    gdm_master_model_inst.do_read(a, c);
  endtask : rd
  function automatic logic [15:0] w(input int i);
    return gdm_master_model_inst.words[i];
  endfunction : w
  task automatic settle;
    repeat (3) @(negedge sys_clk);
  endtask : settle
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_scale;
    logic [15:0] mult [4] = '{16'h0001, 16'h000A, 16'h0064, 16'h03E8};
    for (int k = 0; k < 4; k++) begin
      sensor_in[0] = mk(16'h0005, 2'(k));
      settle();
      rd(16'h0000, 5'h01);
      chk16("scaled", 16'(16'h0005 * mult[k]), gdm_master_model_inst.words[0]);
    end
    sensor_in[0] = mk(16'h0046, 2'h3);
    settle();
    rd(16'h0000, 5'h01);
    chk16("clamped", 16'hFFFE, gdm_master_model_inst.words[0]);
    sensor_in[0].failing = 1'b1;
    settle();
    rd(16'h0000, 5'h01);
    chk16("error value", 16'hFFFF, gdm_master_model_inst.words[0]);
    $display("test scale done");
  endtask : t_scale
  task automatic t_status;
    gdm_pkg::gdm_sensor_s s;
    logic alarm;
    for (int k = 0; k <= 12; k++) begin
      s = mk(16'h0032, 2'h0);
      case (k)
        0: s.reading_negative = 1'b1;
        1: s.meas = 16'h0096;
        2: s.meas = 16'h012C;
        3: s.meas = 16'h07D0;
        4: s.meas = 16'h0032;
        5: s.meas = 16'h0002;
        6: s.failing = 1'b1;
        7: s.needs_cal = 1'b1;
        8: s.installed = 1'b0;
        9: s.dual_range = 1'b1;
        default: s.err_code = 2'(k - 9);
      endcase
      if (k == 9) begin
        s.meas = 16'h07D0;
      end
      sensor_in[0] = s;
      alarm = !(k == 4 || k == 5 || k == 8);
      settle();
      rd(16'h0020, 5'h01);
      chk16("status code", 16'(k), w(0));
      chk16("overall", {14'h0000, alarm, alarm}, overall_word);
    end
    sensor_in[0] = mk(16'h0032, 2'h0);
    $display("test status done");
  endtask : t_status
  task automatic t_overall;
    logic [15:0] ex [5] = '{16'h0005, 16'h0008, 16'h0010, 16'h0020, 16'h0040};
    for (int b = 0; b < 5; b++) begin
      sys_in = 5'h10 >> b;
      settle();
      rd(16'h0040, 5'h03);
      chk16("overall word", ex[b], w(0));
      chk16("internal hours", 16'h1234, w(1));
      chk16("user hours", 16'h0000, w(2));
      if (b == 3) begin
        rd(16'h0000, 5'h04);
        for (int i = 0; i < 4; i++) begin
          chk16("boot value", 16'hFFFF, gdm_master_model_inst.words[i]);
        end
      end
    end
    sys_in = '0;
    $display("test overall done");
  endtask : t_overall
  task automatic t_gas;
    logic [15:0] ex [4] = '{16'hFFFF, 16'h0007, 16'h0015, 16'h0000};
    sensor_in[0].gas_code = 16'shFFFB;
    sensor_in[1].gas_code = 16'sh0007;
    sensor_in[2].gas_code = 16'sh0015;
    sensor_in[3].installed = 1'b0;
    settle();
    rd(16'h0240, 5'h04);
    for (int i = 0; i < 4; i++) begin
      chk16("gas type", ex[i], gdm_master_model_inst.words[i]);
    end
    for (int i = 0; i < 4; i++) begin
      sensor_in[i] = mk(16'h0032, 2'h0);
    end
    $display("test gas done");
  endtask : t_gas
  task automatic t_limits;
    settle();
    rd(16'h0000, 5'h10);
    chk16("burst size", 16'h0010, 16'(gdm_master_model_inst.words.size()));
    chk1("read busy", 1'b1, gdm_master_model_inst.busy_seen);
    for (int i = 0; i < 16; i++) begin
      chk16("burst word", (i < 4) ? 16'h0032 : 16'h0000, w(i));
    end
    rd(16'h0040, 5'h02);
    chk16("pair size", 16'h0002, 16'(gdm_master_model_inst.words.size()));
    chk16("pair overall", 16'h0000, w(0));
    chk16("pair internal", 16'h1234, w(1));
    rd(16'h0200, 5'h01);
    chk16("lower limit", 16'h0064, w(0));
    rd(16'h0220, 5'h01);
    chk16("upper limit", 16'h00C8, w(0));
    rd(16'h0000, 5'h11);
    chk16("count fault", 16'h0003, {8'h00, gdm_master_model_inst.fault_code});
    chk1("fault idle", 1'b0, gdm_master_model_inst.busy_seen);
    rd(16'h0000, 5'h00);
    chk16("zero fault", 16'h0003, {8'h00, gdm_master_model_inst.fault_code});
    rd(16'h025F, 5'h02);
    chk16("addr fault", 16'h0002, {8'h00, gdm_master_model_inst.fault_code});
    $display("test limits done");
  endtask : t_limits
  task automatic t_coil;
    logic [15:0] v [3] = '{16'h0000, 16'h00FF, 16'hFF00};
    for (int i = 0; i < 3; i++) begin
      gdm_master_model_inst.do_coil(16'h1001, v[i]);
      chk1("coil ack", 1'b1, gdm_master_model_inst.got_ack);
      chk1("pump reset", i != 0, pump_reset);
    end
    repeat (3) begin
      @(negedge sys_clk);
      hour_tick = 1'b1;
      @(negedge sys_clk);
      hour_tick = 1'b0;
    end
    gdm_master_model_inst.do_coil(16'h1002, 16'h0000);
    @(negedge sys_clk);
    chk16("hours kept", 16'h0003, user_pump_hours);
    gdm_master_model_inst.do_coil(16'h1002, 16'h00FF);
    @(negedge sys_clk);
    chk16("hours cleared", 16'h0000, user_pump_hours);
    gdm_master_model_inst.do_coil(16'h1FFF, 16'hFF00);
    chk1("reserved ack", 1'b1, gdm_master_model_inst.got_ack);
    chk1("reserved idle", 1'b0, pump_reset);
    gdm_master_model_inst.do_coil(16'h1000, 16'hFF00);
    chk16("coil addr fault", 16'h0002, {8'h00, gdm_master_model_inst.fault_code});
    gdm_master_model_inst.do_coil(16'h1001, 16'h1234);
    chk1("value fault", 1'b1, gdm_master_model_inst.got_fault);
    chk1("no reset", 1'b0, pump_reset);
    $display("test coil done");
  endtask : t_coil
  initial begin
    for (int i = 0; i < 4; i++) begin
      sensor_in[i] = mk(16'h0032, 2'h0);
    end
    repeat (10) @(negedge sys_clk);
    chk16("reset overall", 16'h0000, overall_word);
    chk16("reset hours", 16'h0000, user_pump_hours);
    rst = 1'b0;
    t_scale();
    t_status();
    t_overall();
    t_gas();
    t_limits();
    t_coil();
    end_sim();
  end
endmodule : tb
